/* File: verilog/icr_pkg.sv */
/*
 * Constants of the control register block of an on-chip I2C controller.
 * Assumes a 20 MHz system clock and a plain register port with 12-bit addresses.
 */
package icr_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 8;
   localparam logic [11:0] ADDR_DATA     = 12'h0f50;
   localparam logic [11:0] ADDR_STATUS   = 12'h0f51;
   localparam logic [11:0] ADDR_CONTROL  = 12'h0f52;
   localparam logic [11:0] ADDR_BAUD_HI  = 12'h0f53;
   localparam logic [11:0] ADDR_BAUD_LO  = 12'h0f54;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int          CTL_ENABLE    = 7;
   localparam int          CTL_START     = 6;
   localparam int          CTL_STOP      = 5;
   localparam int          CTL_BAUD_TIMER_IRQ_REQUEST      = 4;
   localparam int          CTL_TXI       = 3;
   localparam int          CTL_NAK       = 2;
   localparam int          CTL_FLUSH     = 1;
   localparam int          CTL_FILTER    = 0;
   localparam logic [7:0]  CTL_RESET     = 8'h00;

   // ************************************************************
   // Status register fields
   // ************************************************************
   localparam int          STS_TX_DATA_EMPTY_FLAG      = 7;
   localparam int          STS_ARBLOST   = 2;

   // ************************************************************
   // Baud reload and filter timing
   // ************************************************************
   localparam logic [7:0]  BAUD_RESET    = 8'h00ff;
   localparam logic [15:0] BAUD_ONE      = 16'h0001;
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          FILT_DELAY    = 3;

   typedef enum logic [1:0] {
      ICR_IDLE,
      ICR_WAIT_DATA,
      ICR_REQUEST
   } icr_start_state_t;
endpackage

/* File: verilog/icr_ctrl.sv */
/*
 * Control register logic of an I2C controller: control bits, start/stop/nak
 * requests, data holding register, baud timer and input spike filters.
 * Assumes a separate bus engine that reports byte, start and stop progress.
 */
// Chosen here: the strobed register port.
// What this block does
// - Enable bit switches controller on/off; filters run regardless, timer mode interrupts only while off.
// - Start, stop, nak set by one only.
// - Start issued as controller, then self-cleared.
// - Start waits for a loaded byte.
// - Start mid-byte gives repeated start afterwards.
// - Pending stop completes before start.
// - Start during target transfer cancelled, arbitration lost.
// - Stop sent after current byte completes.
// - Stop bit cleared after stop or disable.
// - Stop during target transfer cleared, none sent.
// - Baud timer request ignored while enabled.
// - Disabled timer mode interrupts at count one.
// - Tx empty interrupt gated by enable bit.
// - Nak bit answers next received byte.
// - Nak bit clears after nak or disable.
// - Flush empties data register, sets empty flag.
// - Flush bit always reads zero.
// - Filter bit enables SDA/SCL low-pass filters.
// - Filters reject pulses under two cycles.
// - Enabled filters delay inputs three cycles.
// - Data write clears tx empty flag.
// - Baud reload is sixteen bits from two bytes.
`timescale 1ns/100ps
module icr_ctrl (
   input  wire logic        i_clk_sys,
   input  wire logic        i_arst_n,
   input  wire logic [11:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   input  wire logic        i_master_mode,
   input  wire logic        i_target_active,
   input  wire logic        i_byte_busy,
   input  wire logic        i_shift_full,
   input  wire logic        i_tx_take,
   input  wire logic        i_start_done,
   input  wire logic        i_stop_done,
   input  wire logic        i_nak_sent,
   input  wire logic        i_sda,
   input  wire logic        i_scl,
   output logic             o_enable,
   output logic             o_start_req,
   output logic             o_stop_req,
   output logic             o_nak_req,
   output logic      [7:0]  o_tx_byte,
   output logic             o_tx_valid,
   output logic             o_tx_empty_irq,
   output logic             o_baud_tick,
   output logic             o_baud_irq,
   output logic             o_sda_filt,
   output logic             o_scl_filt
);
   // ************************************************************
   // Register decode
   // ************************************************************
   logic       wr_ctl;
   logic       en_next;
   logic       en_q;
   logic       start_q;
   logic       stop_q;
   logic       nak_q;
   logic       baud_timer_irq_request_q;
   logic       txi_q;
   logic       filt_q;
   logic       tx_data_empty_flag_q;
   logic       arb_q;
   logic       arb_set;
   logic [7:0] data_q;
   logic [7:0] brh_q;
   logic [7:0] brl_q;
   logic [15:0] cnt_q;
   logic       start_go;
   logic       stop_go;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   assign wr_ctl  = i_wr && hit(i_addr, icr_pkg::ADDR_CONTROL);
   assign en_next = wr_ctl ? i_wdata[icr_pkg::CTL_ENABLE] : en_q;

   // ************************************************************
   // Plain control bits
   // ************************************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         en_q   <= 1'b0;
         baud_timer_irq_request_q <= 1'b0;
         txi_q  <= 1'b0;
         filt_q <= 1'b0;
      end else if (wr_ctl) begin
         en_q   <= i_wdata[icr_pkg::CTL_ENABLE];
         baud_timer_irq_request_q <= i_wdata[icr_pkg::CTL_BAUD_TIMER_IRQ_REQUEST];
         txi_q  <= i_wdata[icr_pkg::CTL_TXI];
         filt_q <= i_wdata[icr_pkg::CTL_FILTER];
      end
   end

   // ************************************************************
   // Start request
   // ************************************************************
   // A write of one wins over any hardware clear in the same cycle.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         start_q <= 1'b0;
      end else if (!en_next) begin
         start_q <= 1'b0;
      end else if (wr_ctl && i_wdata[icr_pkg::CTL_START]) begin
         start_q <= 1'b1;
      end else if (i_start_done || (start_q && i_target_active)) begin
         start_q <= 1'b0;
      end
   end

   // Stop first, a loaded byte, and no byte in flight.
   assign start_go = en_q && start_q && !stop_q && !i_target_active
                     && (!tx_data_empty_flag_q || i_shift_full)
                     && !i_byte_busy;

   // ************************************************************
   // Stop request
   // ************************************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stop_q <= 1'b0;
      end else if (!en_next) begin
         stop_q <= 1'b0;
      end else if (wr_ctl && i_wdata[icr_pkg::CTL_STOP]) begin
         stop_q <= 1'b1;
      end else if (i_stop_done || (stop_q && i_target_active)) begin
         stop_q <= 1'b0;
      end
   end

   assign stop_go = en_q && stop_q && i_master_mode && !i_target_active
                    && !i_byte_busy;

   // ************************************************************
   // Not-acknowledge request
   // ************************************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         nak_q <= 1'b0;
      end else if (!en_next) begin
         nak_q <= 1'b0;
      end else if (wr_ctl && i_wdata[icr_pkg::CTL_NAK]) begin
         nak_q <= 1'b1;
      end else if (i_nak_sent) begin
         nak_q <= 1'b0;
      end
   end

   // ************************************************************
   // Data holding register and empty flag
   // ************************************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         data_q <= 8'h00;
         tx_data_empty_flag_q <= 1'b1;
      end else if (wr_ctl && i_wdata[icr_pkg::CTL_FLUSH]) begin
         data_q <= 8'h00;
         tx_data_empty_flag_q <= 1'b1;
      end else if (i_wr && hit(i_addr, icr_pkg::ADDR_DATA)) begin
         data_q <= i_wdata;
         tx_data_empty_flag_q <= 1'b0;
      end else if (i_tx_take) begin
         tx_data_empty_flag_q <= 1'b1;
      end
   end

   // ************************************************************
   // Arbitration lost flag
   // ************************************************************
   // Set wins over the clear that a status read causes.
   assign arb_set = en_q && start_q && i_target_active;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         arb_q <= 1'b0;
      end else if (arb_set) begin
         arb_q <= 1'b1;
      end else if (i_rd && hit(i_addr, icr_pkg::ADDR_STATUS)) begin
         arb_q <= 1'b0;
      end
   end

   // ************************************************************
   // Baud reload bytes and generator
   // ************************************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         brh_q <= icr_pkg::BAUD_RESET;
         brl_q <= icr_pkg::BAUD_RESET;
      end else if (i_wr) begin
         if (hit(i_addr, icr_pkg::ADDR_BAUD_HI)) begin
            brh_q <= i_wdata;
         end
         if (hit(i_addr, icr_pkg::ADDR_BAUD_LO)) begin
            brl_q <= i_wdata;
         end
      end
   end

   // A reload of zero counts the full 65536 cycles through the wrap.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q       <= 16'h0000;
         o_baud_tick <= 1'b0;
         o_baud_irq  <= 1'b0;
      end else if (en_q || baud_timer_irq_request_q) begin
         o_baud_tick <= en_q && (cnt_q == icr_pkg::BAUD_ONE);
         o_baud_irq  <= !en_q && (cnt_q == icr_pkg::BAUD_ONE);
         if (cnt_q == icr_pkg::BAUD_ONE) begin
            cnt_q <= {brh_q, brl_q};
         end else begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end else begin
         cnt_q       <= {brh_q, brl_q};
         o_baud_tick <= 1'b0;
         o_baud_irq  <= 1'b0;
      end
   end

   // ************************************************************
   // Input spike filters
   // ************************************************************
   // Two agreeing samples are needed, so a one-cycle glitch never passes.
   logic [1:0] sda_s_q;
   logic [1:0] scl_s_q;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sda_s_q    <= 2'b11;
         scl_s_q    <= 2'b11;
         o_sda_filt <= 1'b1;
         o_scl_filt <= 1'b1;
      end else begin
         sda_s_q <= {sda_s_q[0], i_sda};
         scl_s_q <= {scl_s_q[0], i_scl};
         if (!filt_q) begin
            o_sda_filt <= i_sda;
            o_scl_filt <= i_scl;
         end else begin
            if (sda_s_q[0] == sda_s_q[1]) begin
               o_sda_filt <= sda_s_q[1];
            end
            if (scl_s_q[0] == scl_s_q[1]) begin
               o_scl_filt <= scl_s_q[1];
            end
         end
      end
   end

   // ************************************************************
   // Registered outputs and read port
   // ************************************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_enable       <= 1'b0;
         o_start_req    <= 1'b0;
         o_stop_req     <= 1'b0;
         o_nak_req      <= 1'b0;
         o_tx_byte      <= 8'h00;
         o_tx_valid     <= 1'b0;
         o_tx_empty_irq <= 1'b0;
      end else begin
         o_enable       <= en_q;
         o_start_req    <= start_go;
         o_stop_req     <= stop_go;
         o_nak_req      <= en_q && nak_q;
         o_tx_byte      <= data_q;
         o_tx_valid     <= en_q && !tx_data_empty_flag_q;
         o_tx_empty_irq <= en_q && txi_q && tx_data_empty_flag_q;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 8'h00;
      end else if (!i_rd) begin
         o_rdata <= 8'h00;
      end else begin
         unique case (i_addr)
            icr_pkg::ADDR_CONTROL: o_rdata <= {en_q, start_q, stop_q, baud_timer_irq_request_q, txi_q,
                                               nak_q, 1'b0, filt_q};
            icr_pkg::ADDR_STATUS:  o_rdata <= {tx_data_empty_flag_q, 4'h0, arb_q, 2'b00};
            icr_pkg::ADDR_DATA:    o_rdata <= data_q;
            icr_pkg::ADDR_BAUD_HI: o_rdata <= brh_q;
            icr_pkg::ADDR_BAUD_LO: o_rdata <= brl_q;
            default:               o_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);

   AST_WRITE_ZERO_KEEPS: assert property (
      start_q && en_next && wr_ctl && !i_wdata[icr_pkg::CTL_START]
      && !i_start_done && !i_target_active |=> start_q)
      else $error("start bit cleared by a write of zero");

   AST_DISABLE_CLEARS: assert property (
      wr_ctl && !i_wdata[icr_pkg::CTL_ENABLE] |=> !start_q && !stop_q && !nak_q)
      else $error("requests survive disable");

   AST_START_NEEDS_DATA: assert property (
      tx_data_empty_flag_q && !i_shift_full |=> !o_start_req)
      else $error("start issued with no byte loaded");

   AST_START_AFTER_BYTE: assert property (
      i_byte_busy |=> !o_start_req)
      else $error("start issued during a byte");

   AST_STOP_FIRST: assert property (
      stop_q |=> !o_start_req)
      else $error("start issued before pending stop");

   AST_TARGET_CANCEL: assert property (
      en_q && start_q && i_target_active && !(wr_ctl && i_wdata[icr_pkg::CTL_START])
      |=> !start_q && arb_q)
      else $error("start not cancelled in target transfer");

   AST_STOP_CLEARED: assert property (
      en_q && stop_q && i_stop_done && !wr_ctl |=> !stop_q ##1 !o_stop_req)
      else $error("stop bit not cleared after stop");

   AST_BAUD_TIMER_IRQ_REQUEST_IGNORED: assert property (
      en_q |=> !o_baud_irq)
      else $error("baud interrupt while enabled");

   AST_TIMER_PULSE: assert property (
      !en_q && baud_timer_irq_request_q && cnt_q == icr_pkg::BAUD_ONE
      |=> o_baud_irq)
      else $error("timer interrupt missing at count one");

   AST_TXI_GATE: assert property (
      !txi_q |=> !o_tx_empty_irq)
      else $error("empty interrupt without enable");

   AST_NAK_CLEAR: assert property (
      nak_q && i_nak_sent && en_next && !(wr_ctl && i_wdata[icr_pkg::CTL_NAK])
      |=> !nak_q)
      else $error("nak bit not cleared");

   AST_FLUSH: assert property (
      wr_ctl && i_wdata[icr_pkg::CTL_FLUSH] |=> tx_data_empty_flag_q && data_q == 8'h00)
      else $error("flush did not empty data register");

   AST_FLUSH_READ: assert property (
      $past(i_rd) && $past(i_addr) == icr_pkg::ADDR_CONTROL
      |-> !o_rdata[icr_pkg::CTL_FLUSH])
      else $error("flush bit read as one");

   AST_FILTER_DELAY: assert property (
      $past(filt_q) && $past(i_sda, 2) == $past(i_sda, icr_pkg::FILT_DELAY)
      |-> o_sda_filt == $past(i_sda, icr_pkg::FILT_DELAY))
      else $error("filter delay not three cycles");

   AST_DATA_WRITE: assert property (
      i_wr && i_addr == icr_pkg::ADDR_DATA && !wr_ctl |=> !tx_data_empty_flag_q)
      else $error("data write left empty flag set");

   COV_START: cover property (o_start_req ##[1:50] i_start_done);
   COV_STOP_THEN_START: cover property (stop_q && start_q ##[1:50] o_start_req);
   COV_CANCEL: cover property (arb_set);
   COV_TIMER: cover property (o_baud_irq);
endmodule // icr_ctrl

/* File: test/icr_engine_model.sv */
/* Behavioural model of the bus engine beside the control block.
   Assumes one system clock; the bench sets the answer latency. */
`timescale 1ns/100ps
module icr_engine_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_arst_n,
   input  wire logic       i_enable,
   input  wire logic       i_master,
   input  wire logic       i_start_req,
   input  wire logic       i_stop_req,
   input  wire logic       i_nak_req,
   input  wire logic       i_tx_valid,
   input  wire logic [3:0] i_lat,
   output logic            o_tx_take,
   output logic            o_shift_full,
   output logic            o_start_done,
   output logic            o_stop_done,
   output logic            o_nak_sent
);
   logic [2:0] req;
   logic [2:0] ack;
   logic [2:0] done;
   logic [3:0] cnt [3];
   assign req = {i_nak_req, i_start_req, i_stop_req};
   assign {o_nak_sent, o_start_done, o_stop_done} = done;
   // One answer per request; a slow latency keeps requests standing longer.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack <= '0;
         done <= '0;
         cnt <= '{default: '0};
         o_tx_take <= 1'b0;
         o_shift_full <= 1'b0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            done[k] <= 1'b0;
            if (!req[k]) begin
               ack[k] <= 1'b0;
               cnt[k] <= '0;
            end else if (!ack[k] && cnt[k] == i_lat) begin
               done[k] <= 1'b1;
               ack[k] <= 1'b1;
            end else if (!ack[k]) begin
               cnt[k] <= cnt[k] + 4'h1;
            end
         end
         o_tx_take <= i_master && i_tx_valid && !o_shift_full && !o_tx_take;
         if (o_tx_take) begin
            o_shift_full <= 1'b1;
         end
         if (!i_enable) begin
            o_shift_full <= 1'b0;
         end
      end
   end
endmodule // icr_engine_model

/* File: test/icr_ctrl_tb_top.sv */
/* Self-checking bench of the control register block.
   Assumes the engine model stands in for the bus engine; the bench is the bus. */
`timescale 1ns/100ps
module icr_ctrl_tb_top;
   localparam logic [11:0] CTL = icr_pkg::ADDR_CONTROL;
   localparam logic [11:0] STS = icr_pkg::ADDR_STATUS;
   logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [11:0] addr = '0;
   logic [7:0]  wdata = '0, rdata, tx_byte;
   logic        master = 1'b0, target = 1'b0, busy = 1'b0, sda = 1'b1, scl = 1'b1;
   logic [3:0]  lat = 4'h2;
   logic        shift_full, tx_take, start_done, stop_done, nak_sent, enable;
   logic        start_req, stop_req, nak_req, tx_valid, txirq, tick, baud_timer_irq_request, sda_f, scl_f;
   int          bad_count = 0, check_count = 0;
   always #25 clk = ~clk;
   icr_ctrl icr_ctrl_inst (.i_clk_sys(clk), .i_arst_n(arst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_master_mode(master),
      .i_target_active(target), .i_byte_busy(busy), .i_shift_full(shift_full),
      .i_tx_take(tx_take), .i_start_done(start_done), .i_stop_done(stop_done),
      .i_nak_sent(nak_sent), .i_sda(sda), .i_scl(scl), .o_enable(enable),
      .o_start_req(start_req), .o_stop_req(stop_req), .o_nak_req(nak_req),
      .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .o_tx_empty_irq(txirq),
      .o_baud_tick(tick), .o_baud_irq(baud_timer_irq_request), .o_sda_filt(sda_f), .o_scl_filt(scl_f));
   icr_engine_model icr_engine_model_inst (.i_clk_sys(clk), .i_arst_n(arst_n),
      .i_enable(enable), .i_master(master), .i_start_req(start_req),
      .i_stop_req(stop_req), .i_nak_req(nak_req), .i_tx_valid(tx_valid), .i_lat(lat),
      .o_tx_take(tx_take), .o_shift_full(shift_full), .o_start_done(start_done),
      .o_stop_done(stop_done), .o_nak_sent(nak_sent));
   // ************************************************************
   // Bus tasks and comparisons
   // ************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_byte(n, {7'h00, e}, {7'h00, g});
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_byte(n, e, rdata);
   endtask
   function automatic logic reqv(input int w);
      return (w == 0) ? stop_req : ((w == 1) ? start_req : nak_req);
   endfunction
   task automatic wait_req(input int w, input logic v, input string n);
      for (int i = 0; i < 40 && reqv(w) !== v; i++) cyc(1);
      chk_bit(n, v, reqv(w));
   endtask
   task automatic pulses(output int nb, output int nt);
      nb = 0;
      nt = 0;
      for (int i = 0; i < 40; i++) begin
         cyc(1);
         nb += (baud_timer_irq_request === 1'b1);
         nt += (tick === 1'b1);
      end
   endtask
   task automatic filt(output int ns, output int nc);
      @(posedge clk);
      sda <= 1'b0;
      scl <= 1'b0;
      ns = 0;
      nc = 0;
      for (int i = 1; i <= 8; i++) begin
         cyc(1);
         if (ns == 0 && sda_f === 1'b0) ns = i;
         if (nc == 0 && scl_f === 1'b0) nc = i;
      end
      @(posedge clk);
      sda <= 1'b1;
      scl <= 1'b1;
      cyc(8);
   endtask
   task automatic final_report;
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      int n;
      int m;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rchk(CTL, 8'h00, "ctl_reset");
      rchk(STS, 8'h80, "sts_reset");
      rchk(icr_pkg::ADDR_BAUD_HI, 8'hff, "baud_hi_reset");
      rchk(12'h0f5f, 8'h00, "unmapped");
      wreg(CTL, 8'h40);
      rchk(CTL, 8'h00, "start_while_off");
      wreg(CTL, 8'h80);
      cyc(2);
      chk_bit("enable", 1'b1, enable);
      wreg(CTL, 8'h88);
      cyc(2);
      chk_bit("tx_irq_empty", 1'b1, txirq);
      wreg(icr_pkg::ADDR_DATA, 8'h5a);
      cyc(2);
      chk_bit("tx_irq_full", 1'b0, txirq);
      chk_byte("tx_byte", 8'h5a, tx_byte);
      wreg(CTL, 8'h8a);
      cyc(2);
      chk_bit("tx_valid_flush", 1'b0, tx_valid);
      chk_bit("tx_irq_flush", 1'b1, txirq);
      rchk(CTL, 8'h88, "flush_reads_zero");
      rchk(STS, 8'h80, "empty_after_flush");
      wreg(CTL, 8'h80);
      cyc(2);
      chk_bit("tx_irq_masked", 1'b0, txirq);
      // Start with nothing to send must wait for a byte.
      @(posedge clk);
      master <= 1'b1;
      wreg(CTL, 8'hc0);
      cyc(8);
      chk_bit("start_no_data", 1'b0, start_req);
      wreg(icr_pkg::ADDR_DATA, 8'h33);
      wait_req(1, 1'b1, "start_with_data");
      wait_req(1, 1'b0, "start_cleared");
      rchk(CTL, 8'h80, "start_bit_clear");
      @(posedge clk);
      busy <= 1'b1;
      wreg(CTL, 8'hc0);
      cyc(6);
      chk_bit("start_mid_byte", 1'b0, start_req);
      wreg(CTL, 8'h80);
      rchk(CTL, 8'hc0, "start_write_zero");
      @(posedge clk);
      busy <= 1'b0;
      wait_req(1, 1'b1, "restart_after_byte");
      wait_req(1, 1'b0, "restart_cleared");
      lat <= 4'h8;
      wreg(CTL, 8'he0);
      wait_req(0, 1'b1, "stop_first");
      chk_bit("start_held_by_stop", 1'b0, start_req);
      wait_req(0, 1'b0, "stop_cleared");
      wait_req(1, 1'b1, "start_after_stop");
      wait_req(1, 1'b0, "start_done_clear");
      wreg(CTL, 8'ha0);
      wait_req(0, 1'b1, "stop_again");
      wreg(CTL, 8'h00);
      wait_req(0, 1'b0, "stop_disable");
      rchk(CTL, 8'h00, "stop_bit_disable");
      // Start and stop requests during a target transfer are dropped.
      @(posedge clk);
      master <= 1'b0;
      target <= 1'b1;
      wreg(CTL, 8'hc0);
      cyc(2);
      chk_bit("start_target", 1'b0, start_req);
      rchk(CTL, 8'h80, "start_cancel");
      rchk(STS, 8'h84, "arb_lost_set");
      rchk(STS, 8'h80, "arb_lost_read");
      wreg(CTL, 8'ha0);
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         chk_bit("stop_target", 1'b0, stop_req);
      end
      rchk(CTL, 8'h80, "stop_cancel");
      @(posedge clk);
      target <= 1'b0;
      lat <= 4'hf;
      wreg(CTL, 8'h84);
      cyc(2);
      chk_bit("nak_req", 1'b1, nak_req);
      wreg(CTL, 8'h80);
      rchk(CTL, 8'h84, "nak_write_zero");
      wait_req(2, 1'b0, "nak_sent");
      rchk(CTL, 8'h80, "nak_bit_clear");
      wreg(CTL, 8'h84);
      wreg(CTL, 8'h00);
      rchk(CTL, 8'h00, "nak_disable");
      // The counter is reloaded while idle, so the first pulse comes within a period.
      wreg(icr_pkg::ADDR_BAUD_HI, 8'h00);
      wreg(icr_pkg::ADDR_BAUD_LO, 8'h04);
      rchk(icr_pkg::ADDR_BAUD_LO, 8'h04, "baud_lo");
      wreg(CTL, 8'h10);
      for (int i = 0; i < 40 && baud_timer_irq_request !== 1'b1; i++) cyc(1);
      pulses(n, m);
      chk_byte("timer_irqs", 8'd10, n[7:0]);
      wreg(CTL, 8'h90);
      cyc(8);
      pulses(n, m);
      chk_byte("timer_irqs_enabled", 8'd0, n[7:0]);
      chk_byte("baud_ticks", 8'd10, m[7:0]);
      wreg(CTL, 8'h00);
      filt(n, m);
      chk_byte("sda_unfiltered", 8'd1, n[7:0]);
      chk_byte("scl_unfiltered", 8'd1, m[7:0]);
      wreg(CTL, 8'h01);
      filt(n, m);
      chk_byte("sda_delay", 8'd3, n[7:0]);
      chk_byte("scl_delay", 8'd3, m[7:0]);
      @(posedge clk);
      sda <= 1'b0;
      scl <= 1'b0;
      @(posedge clk);
      sda <= 1'b1;
      scl <= 1'b1;
      n = 0;
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         n += (sda_f !== 1'b1) + (scl_f !== 1'b1);
      end
      chk_byte("spike_rejected", 8'd0, n[7:0]);
      final_report();
   end
   // The whole sequence needs well under a thousand cycles, so this span is generous.
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule // icr_ctrl_tb_top
